// ==== hdl/phy_mgmt_map.vh ====
// Constants of the management and configuration block
`ifndef PHY_MGMT_MAP_VH
`define PHY_MGMT_MAP_VH

// ==========================================================
// Timing
`define PCLK_PERIOD_NS 10
`define HW_RESET_WAIT_NS 1000000
`define SW_RESET_NS 2000
`define MDC_MAX_KHZ 8000
// Cycle counts at the 10 ns clock, sized to their counters
`define HW_RESET_WAIT_CYCLES 20'h186a0
`define SW_RESET_CYCLES 8'hc8

// ==========================================================
// APB word offsets
`define APB_LINE_STAT 8'h00
`define APB_CFG_VIEW 8'h04
`define APB_INT_VIEW 8'h08

// ==========================================================
// Management register numbers
`define MREG_CONTROL 5'h00
`define MREG_STATUS 5'h01
`define MREG_ADVERT 5'h04
`define MREG_INT_ENABLE 5'h12
`define MREG_INT_STATUS 5'h13

// ==========================================================
// Control register bit positions
`define CTL_SW_RESET_BIT 15
`define CTL_LOOPBACK_BIT 14
`define CTL_SPEED_BIT 13
`define CTL_AN_ENABLE_BIT 12
`define CTL_POWER_DOWN_BIT 11
`define CTL_AN_RESTART_BIT 9
`define FULL_DUPLEX_BIT 8

// ==========================================================
// Advertisement, interrupt fields and reset values
`define ADVERTISE_10_HALF_BIT 5
`define ADV_SELECTOR 5'h01
`define ADV_ALL_MODES 4'hf
`define INT_GLOBAL_EN_BIT 1
`define INT_SRC_LSB 4
`define INT_ENABLE_RESET 16'h0000
`define MEM_RESET 16'h0000

// ==========================================================
// Frame layout
`define MDIO_PREAMBLE_BITS 6'h20
`define MDIO_OP_READ 2'h2
`define MDIO_OP_WRITE 2'h1
`define MDIO_HDR_LAST 5'h0c
`define MDIO_DATA_LAST 5'h0f

`endif

// ==== hdl/mdio_frame_engine.v ====
// Serial management frame receiver and read data driver
`timescale 1ns/100ps
`include "phy_mgmt_map.vh"

module mdio_frame_engine (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Sampled serial line
   input wire mdc_rise,
   input wire mdio_bit,
   input wire enable,
   input wire [4:0] my_addr,
   // Register side
   input wire [15:0] rd_data,
   output reg rd_req_ff,
   output reg wr_req_ff,
   output reg [4:0] reg_addr_ff,
   output reg [15:0] wr_data_ff,
   // Line drive
   output reg mdio_out_ff,
   output reg mdio_oe_ff
);

localparam S_PRE = 5'b00001;
localparam S_HDR = 5'b00010;
localparam S_TA = 5'b00100;
localparam S_RD = 5'b01000;
localparam S_WR = 5'b10000;

reg [4:0] state_ff;
reg [4:0] cnt_ff;
reg [5:0] ones_ff;
reg [15:0] shift_ff;
reg [15:0] dat_ff;
reg hit_ff;
reg is_rd_ff;
wire [12:0] hdr = {shift_ff[11:0], mdio_bit};
wire hdr_ok = hdr[12] && (hdr[9:5] == my_addr) && enable;

// ==========================================================
// Frame sequencer
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      state_ff <= S_PRE;
      cnt_ff <= 5'h00;
      ones_ff <= 6'h00;
      shift_ff <= 16'h0000;
      dat_ff <= 16'h0000;
      hit_ff <= 1'b0;
      is_rd_ff <= 1'b0;
      rd_req_ff <= 1'b0;
      wr_req_ff <= 1'b0;
      reg_addr_ff <= 5'h00;
      wr_data_ff <= 16'h0000;
      mdio_out_ff <= 1'b0;
      mdio_oe_ff <= 1'b0;
   end else begin
      rd_req_ff <= 1'b0;
      wr_req_ff <= 1'b0;
      if (rd_req_ff) begin
         dat_ff <= rd_data;
      end
      if (!enable) begin
         // Refused access: line released, frame dropped
         state_ff <= S_PRE;
         ones_ff <= 6'h00;
         mdio_oe_ff <= 1'b0;
      end else if (mdc_rise) begin
         case (state_ff)
            S_PRE: begin
               if (mdio_bit) begin
                  if (ones_ff != `MDIO_PREAMBLE_BITS) begin
                     ones_ff <= ones_ff + 6'h01;
                  end
               end else if (ones_ff == `MDIO_PREAMBLE_BITS) begin
                  state_ff <= S_HDR;
                  cnt_ff <= 5'h00;
               end else begin
                  ones_ff <= 6'h00;
               end
            end
            S_HDR: begin
               shift_ff <= {shift_ff[14:0], mdio_bit};
               cnt_ff <= cnt_ff + 5'h01;
               if (cnt_ff == `MDIO_HDR_LAST) begin
                  state_ff <= S_TA;
                  cnt_ff <= 5'h00;
                  reg_addr_ff <= hdr[4:0];
                  is_rd_ff <= (hdr[11:10] == `MDIO_OP_READ);
                  hit_ff <= hdr_ok && ((hdr[11:10] == `MDIO_OP_READ) ||
                                       (hdr[11:10] == `MDIO_OP_WRITE));
                  rd_req_ff <= hdr_ok && (hdr[11:10] == `MDIO_OP_READ);
               end
            end
            S_TA: begin
               cnt_ff <= cnt_ff + 5'h01;
               if (cnt_ff == 5'h00) begin
                  // Second turnaround bit driven low on a read
                  mdio_oe_ff <= hit_ff && is_rd_ff;
                  mdio_out_ff <= 1'b0;
               end else begin
                  state_ff <= is_rd_ff ? S_RD : S_WR;
                  cnt_ff <= 5'h00;
                  mdio_out_ff <= dat_ff[15];
                  dat_ff <= {dat_ff[14:0], 1'b0};
               end
            end
            S_RD: begin
               cnt_ff <= cnt_ff + 5'h01;
               mdio_out_ff <= dat_ff[15];
               dat_ff <= {dat_ff[14:0], 1'b0};
               if (cnt_ff == `MDIO_DATA_LAST) begin
                  mdio_oe_ff <= 1'b0;
                  state_ff <= S_PRE;
                  ones_ff <= 6'h00;
               end
            end
            S_WR: begin
               cnt_ff <= cnt_ff + 5'h01;
               shift_ff <= {shift_ff[14:0], mdio_bit};
               if (cnt_ff == `MDIO_DATA_LAST) begin
                  wr_data_ff <= {shift_ff[14:0], mdio_bit};
                  wr_req_ff <= hit_ff;
                  state_ff <= S_PRE;
                  ones_ff <= 6'h00;
               end
            end
            default: begin
               state_ff <= S_PRE;
               ones_ff <= 6'h00;
            end
         endcase
      end
   end
end

endmodule // mdio_frame_engine

// ==== hdl/phy_mgmt_config_control.v ====
// Management port, strap loading, resets, power-down and interrupt pin control
// Behaviour
// - Register set of 32 registers, 16 bits each, bits numbered 0 to 15.
// - Management-disable high: serial reads and writes ignored, straps configure.
// - Management-disable low: serial reads and writes accepted, straps not controlling.
// - Address-select pin sets the device address bit.
// - Interrupt pin driven low only while enable bit 18.1 is one.
// - Register 19 status set by masked events: autoneg done, speed, duplex, link.
// - Power-up, reset, link failure: line set from configuration bits.
// - Management mode: straps load defaults, then serial writes control them.
// - Hardware mode: serial writes rejected, straps set registers at hardware reset.
// - Forced modes run at once; autoneg enable starts negotiation.
// - Power-down pin high: port stopped, pads tri-stated, register access refused.
// - Bit 0.11 shuts the port down, registers remain accessible.
// - Hardware reset samples straps into autoneg and speed configuration.
// - Software reset restores values latched at last hardware reset.
// - Registers unavailable for 1 ms after hardware reset release.
// - Software reset keeps reads working, bit 0.15 clears at completion.
// - Strap 1 low: autoneg off, strap 2 speed, strap 3 duplex.
// - Strap 1 high: autoneg on, speed 100, straps 2,3 pick advertisement.
`timescale 1ns/100ps
`include "phy_mgmt_map.vh"

module phy_mgmt_config_control #(
   parameter [19:0] HW_WAIT_CYC =
      `HW_RESET_WAIT_CYCLES,
   parameter [3:0] PHY_ADDR_HI = 4'h0
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Management pins
   input wire mdc,
   input wire mdio_in,
   output wire mdio_out,
   output wire mdio_oe,
   input wire mgmt_port_disable_pin,
   input wire chip_address_select_pin,
   input wire hard_power_down_pin,
   input wire led_strap_pin_1,
   input wire led_strap_pin_2,
   input wire led_strap_pin_3,
   output reg interrupt_request_pin_n,
   // Line control
   output reg port_enable,
   output reg line_speed_100,
   output reg line_full_duplex,
   output reg autoneg_enable,
   output reg autoneg_start,
   output reg pads_tristate,
   output reg regs_ready
);

localparam [7:0] SW_RESET_CYC =
   `SW_RESET_CYCLES;

// ==========================================================
// Pin synchronisers
wire [7:0] raw_in = {mdc, mdio_in, mgmt_port_disable_pin, chip_address_select_pin,
                     hard_power_down_pin, led_strap_pin_3, led_strap_pin_2,
                     led_strap_pin_1};
reg [7:0] meta_ff;
reg [7:0] sync_ff;
reg mdc_last_ff;

genvar g;
generate
   for (g = 0; g < 8; g = g + 1) begin : g_sync
      always @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            meta_ff[g] <= 1'b0;
            sync_ff[g] <= 1'b0;
         end else begin
            meta_ff[g] <= raw_in[g];
            sync_ff[g] <= meta_ff[g];
         end
      end
   end
endgenerate

wire mdc_s = sync_ff[7];
wire mdio_s = sync_ff[6];
wire mdis_s = sync_ff[5];
wire addr_s = sync_ff[4];
wire pd_s = sync_ff[3];
wire [2:0] strap_s = sync_ff[2:0];

wire mdc_rise = mdc_s & ~mdc_last_ff;

// ==========================================================
// Strap decode
function [15:0] ctl_from_strap;
   input [2:0] s;
   begin
      ctl_from_strap = 16'h0000;
      ctl_from_strap[`CTL_AN_ENABLE_BIT] = s[0];
      ctl_from_strap[`CTL_SPEED_BIT] = s[0] | s[1];
      ctl_from_strap[`FULL_DUPLEX_BIT] = s[2];
   end
endfunction

function [3:0] adv_from_strap;
   input [2:0] s;
   begin
      if (s[0]) begin
         adv_from_strap = {s[2], 1'b1, s[1] & s[2], s[1]};
      end else begin
         adv_from_strap = `ADV_ALL_MODES;
      end
   end
endfunction

// ==========================================================
// State
reg hw_busy_ff;
reg [19:0] hw_cnt_ff;
reg [2:0] strap_ff;
reg sw_busy_ff;
reg [7:0] sw_cnt_ff;
reg [15:0] ctl_ff;
reg [3:0] adv_ff;
reg [15:0] int_en_ff;
reg [3:0] int_st_ff;
reg [3:0] line_stat_ff;
reg [3:0] stat_prev_ff;
reg apply_ff;
reg [15:0] mem_ff [0:31];

wire eng_rd;
wire eng_wr;
wire [4:0] eng_addr;
wire [15:0] eng_wdata;
reg [15:0] rd_mux;

wire acc_ok = !hw_busy_ff && !pd_s && !mdis_s;
wire wr_ok = eng_wr && !sw_busy_ff && !mdis_s;
wire wr_ctl = wr_ok && (eng_addr == `MREG_CONTROL);
wire sw_start = wr_ctl && eng_wdata[`CTL_SW_RESET_BIT];
wire sw_end = sw_busy_ff && (sw_cnt_ff == SW_RESET_CYC - 8'h01);
wire hw_end = hw_busy_ff && (hw_cnt_ff == HW_WAIT_CYC - 20'h00001);
wire link_fail = stat_prev_ff[0] && !line_stat_ff[0];
wire st_clr = eng_rd && (eng_addr == `MREG_INT_STATUS);
wire int_act = int_en_ff[`INT_GLOBAL_EN_BIT] && (int_st_ff != 4'h0);

// ==========================================================
// Serial frame engine
// device address
mdio_frame_engine u_engine (
   .pclk(pclk),
   .presetn(presetn),
   .mdc_rise(mdc_rise),
   .mdio_bit(mdio_s),
   .enable(acc_ok),
   .my_addr({PHY_ADDR_HI, addr_s}),
   .rd_data(rd_mux),
   .rd_req_ff(eng_rd),
   .wr_req_ff(eng_wr),
   .reg_addr_ff(eng_addr),
   .wr_data_ff(eng_wdata),
   .mdio_out_ff(mdio_out),
   .mdio_oe_ff(mdio_oe)
);

// ==========================================================
// Read multiplexer
always @* begin
   case (eng_addr)
      `MREG_CONTROL: rd_mux = ctl_ff;
      `MREG_STATUS: rd_mux = {1'b0, 4'hf, 5'h00, line_stat_ff[3], 1'b0, 1'b1,
                              line_stat_ff[0], 1'b0, 1'b1};
      `MREG_ADVERT: rd_mux = {7'h00, adv_ff, `ADV_SELECTOR};
      `MREG_INT_ENABLE: rd_mux = int_en_ff;
      `MREG_INT_STATUS: rd_mux = {8'h00, int_st_ff, 1'b0, int_act, 2'b00};
      default: rd_mux = mem_ff[eng_addr];
   endcase
end

// ==========================================================
// Hardware and software reset sequencing
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      hw_busy_ff <= 1'b1;
      hw_cnt_ff <= 20'h00000;
      strap_ff <= 3'h0;
      sw_busy_ff <= 1'b0;
      sw_cnt_ff <= 8'h00;
      mdc_last_ff <= 1'b0;
   end else begin
      mdc_last_ff <= mdc_s;
      if (hw_busy_ff) begin
         strap_ff <= strap_s;
         hw_cnt_ff <= hw_cnt_ff + 20'h00001;
         if (hw_end) begin
            hw_busy_ff <= 1'b0;
         end
      end
      if (sw_start) begin
         sw_busy_ff <= 1'b1;
         sw_cnt_ff <= 8'h00;
      end else if (sw_busy_ff) begin
         sw_cnt_ff <= sw_cnt_ff + 8'h01;
         if (sw_end) begin
            sw_busy_ff <= 1'b0;
         end
      end
   end
end

// ==========================================================
// Control and advertisement registers
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      ctl_ff <= 16'h0000;
      adv_ff <= `ADV_ALL_MODES;
   end else if (hw_busy_ff) begin
      ctl_ff <= ctl_from_strap(strap_s);
      adv_ff <= adv_from_strap(strap_s);
   end else if (sw_start) begin
      ctl_ff <= ctl_from_strap(strap_ff) | (16'h0001 << `CTL_SW_RESET_BIT);
      adv_ff <= adv_from_strap(strap_ff);
   end else if (sw_end) begin
      ctl_ff[`CTL_SW_RESET_BIT] <= 1'b0;
   end else if (wr_ctl) begin
      ctl_ff <= eng_wdata;
   end else begin
      ctl_ff[`CTL_AN_RESTART_BIT] <= 1'b0;
      if (wr_ok && (eng_addr == `MREG_ADVERT)) begin
         adv_ff <= eng_wdata[8:`ADVERTISE_10_HALF_BIT];
      end
   end
end

// ==========================================================
// General register storage
// 32 words
generate
   for (g = 0; g < 32; g = g + 1) begin : g_mem
      always @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            mem_ff[g] <= `MEM_RESET;
         end else if (sw_start) begin
            mem_ff[g] <= `MEM_RESET;
         end else if (wr_ok && (eng_addr == g)) begin
            mem_ff[g] <= eng_wdata;
         end
      end
   end
endgenerate

// ==========================================================
// Interrupt enable and status
wire [3:0] evt = {line_stat_ff[3] & ~stat_prev_ff[3],
                  line_stat_ff[1] ^ stat_prev_ff[1],
                  line_stat_ff[2] ^ stat_prev_ff[2],
                  line_stat_ff[0] ^ stat_prev_ff[0]};

always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      int_en_ff <= `INT_ENABLE_RESET;
      int_st_ff <= 4'h0;
      stat_prev_ff <= 4'h0;
      interrupt_request_pin_n <= 1'b1;
   end else begin
      stat_prev_ff <= line_stat_ff;
      if (sw_start) begin
         int_en_ff <= `INT_ENABLE_RESET;
      end else if (wr_ok && (eng_addr == `MREG_INT_ENABLE)) begin
         int_en_ff <= eng_wdata;
      end
      // masked set wins over read clear
      int_st_ff <= ((st_clr | sw_start) ? 4'h0 : int_st_ff) |
                   (evt & int_en_ff[`INT_SRC_LSB + 3:`INT_SRC_LSB]);
      interrupt_request_pin_n <= !(int_act && !pd_s);
   end
end

// ==========================================================
// Line configuration outputs
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      apply_ff <= 1'b0;
      port_enable <= 1'b0;
      line_speed_100 <= 1'b0;
      line_full_duplex <= 1'b0;
      autoneg_enable <= 1'b0;
      autoneg_start <= 1'b0;
      pads_tristate <= 1'b0;
      regs_ready <= 1'b0;
   end else begin
      apply_ff <= hw_end || sw_end || link_fail || (wr_ctl && !sw_start);
      autoneg_start <= 1'b0;
      if (apply_ff) begin
         line_speed_100 <= ctl_ff[`CTL_SPEED_BIT];
         line_full_duplex <= ctl_ff[`FULL_DUPLEX_BIT];
         autoneg_enable <= ctl_ff[`CTL_AN_ENABLE_BIT];
         autoneg_start <= ctl_ff[`CTL_AN_ENABLE_BIT];
      end else if (ctl_ff[`CTL_AN_RESTART_BIT] && ctl_ff[`CTL_AN_ENABLE_BIT]) begin
         autoneg_start <= 1'b1;
      end
      port_enable <= !pd_s && !ctl_ff[`CTL_POWER_DOWN_BIT] && !hw_busy_ff &&
                     !sw_busy_ff;
      pads_tristate <= pd_s;
      regs_ready <= acc_ok;
   end
end

// ==========================================================
// APB slave, zero wait states
wire apb_setup = psel && !penable;
wire apb_wr = psel && penable && pwrite && pready;

always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      line_stat_ff <= 4'h0;
   end else begin
      pready <= apb_setup;
      pslverr <= 1'b0;
      if (apb_wr && (paddr == `APB_LINE_STAT)) begin
         line_stat_ff <= pwdata[3:0];
      end
      if (apb_setup) begin
         prdata <= 32'h00000000;
         case (paddr)
            `APB_LINE_STAT: begin
               if (!pwrite) begin
                  prdata <= {28'h0000000, line_stat_ff};
               end
            end
            `APB_CFG_VIEW: begin
               if (!pwrite) begin
                  prdata <= {12'h000, pd_s, sw_busy_ff, hw_busy_ff, mdis_s, ctl_ff};
               end
               pslverr <= pwrite;
            end
            `APB_INT_VIEW: begin
               if (!pwrite) begin
                  prdata <= {8'h00, int_st_ff, 1'b0, int_act, 2'b00, int_en_ff};
               end
               pslverr <= pwrite;
            end
            default: begin
               pslverr <= 1'b1;
            end
         endcase
      end
   end
end

endmodule // phy_mgmt_config_control

// ==== verif/phy_mgmt_assertions.sv ====
// Port checks for the management and configuration block
`timescale 1ns/100ps
module phy_mgmt_assertions (
   // Clock, reset and bus
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // Pins
   input wire mdio_oe,
   input wire mgmt_port_disable_pin,
   input wire hard_power_down_pin,
   input wire interrupt_request_pin_n,
   input wire pads_tristate,
   input wire regs_ready,
   input wire autoneg_start,
   input wire autoneg_enable
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ============================================
   // Register bus
   a_ready_next: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held");
   a_unmapped_err: assert property (psel && !penable && paddr > 8'h08 |=>
      pslverr && prdata == 32'h0) else $error("unmapped not refused");
   a_ro_write: assert property (psel && !penable && pwrite && paddr[3:2] != 2'h0 |=>
      pslverr) else $error("read-only write taken");
   // ============================================
   // Pins
   a_tri_follow: assert property ($rose(hard_power_down_pin) |-> ##[1:4] pads_tristate)
      else $error("pads not released");
   // Power-down keeps the line and the request pin quiet
   a_pd_quiet: assert property (pads_tristate [*2] |-> !mdio_oe && interrupt_request_pin_n)
      else $error("drive in power-down");
   a_hw_mode_quiet: assert property (mgmt_port_disable_pin [*8] |-> !mdio_oe)
      else $error("drive in hardware mode");
   a_regs_hold: assert property ($rose(presetn) |-> !regs_ready [*8])
      else $error("registers ready too early");
   // Negotiation is only started with it enabled
   a_an_start_en: assert property (autoneg_start |-> autoneg_enable)
      else $error("start without enable");
endmodule // phy_mgmt_assertions

bind phy_mgmt_config_control phy_mgmt_assertions chk_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .mdio_oe(mdio_oe),
   .mgmt_port_disable_pin(mgmt_port_disable_pin), .hard_power_down_pin(hard_power_down_pin),
   .interrupt_request_pin_n(interrupt_request_pin_n), .pads_tristate(pads_tristate),
   .regs_ready(regs_ready), .autoneg_start(autoneg_start), .autoneg_enable(autoneg_enable));

// ==== verif/mdio_station_model.sv ====
// Station management controller model on the serial pins
`timescale 1ns/100ps
module mdio_station_model (
   // Serial pins
   output logic mdc = 1'b0,
   output logic m_oe = 1'b0,
   output logic m_out = 1'b0,
   input wire line_in,
   // Read results
   output logic [15:0] rd_word = 16'h0,
   output logic rd_strobe = 1'b0
);
   // ============================================
   // Frame driver
   // 125 ns period
   task bit_cyc(input logic oe, input logic b);
      begin
         m_oe = oe;
         m_out = b;
         #62.5 mdc = 1'b1;
         rd_word = {rd_word[14:0], line_in};
         #62.5 mdc = 1'b0;
      end
   endtask
   task frame(input logic rd, input logic [4:0] phy, rg, input logic [15:0] v);
      logic [63:0] f;
      integer i;
      begin
         f = {32'hffffffff, 2'b01, rd, !rd, phy, rg, 2'b10, v};
         // Released from turnaround on reads; clock idles low after
         for (i = 63; i >= 0; i--) bit_cyc(!(rd && i < 18), f[i]);
         m_oe = 1'b0;
         #125 rd_strobe = rd;
         #10 rd_strobe = 1'b0;
      end
   endtask
endmodule // mdio_station_model

// ==== verif/phy_mgmt_config_control_test.sv ====
// Self-checking bench for the management and configuration block
`timescale 1ns/100ps
module phy_mgmt_config_control_test;
   // ============================================
   // Wiring
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic dis = 1'b0, asel = 1'b0, pd = 1'b0, an, spd, dup;
   logic [2:0] strap = 3'h0;
   logic [3:0] adv;
   logic [7:0] paddr = 8'h00;
   logic [15:0] d;
   logic [31:0] pwdata = 32'h0;
   logic [33:0] aq[$];
   logic [33:0] nt;
   logic [15:0] mq[$];
   integer errors = 0, num_checks = 0, i;
   wire [31:0] prdata;
   wire [15:0] rd_word;
   wire pready, pslverr, mdc, m_oe, m_out, mdio_out, mdio_oe, irq_n, ready, rd_strobe;
   wire port_on, spd_o, dup_o, an_o, tri_o;
   // Pull-up holds the released line high
   wire mdio_in = mdio_oe ? mdio_out : (m_oe ? m_out : 1'b1);
   always #5 pclk = ~pclk;
   phy_mgmt_config_control #(.HW_WAIT_CYC(20'h00032)) phy_mgmt_config_control_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
      .mgmt_port_disable_pin(dis), .chip_address_select_pin(asel),
      .hard_power_down_pin(pd), .led_strap_pin_1(strap[0]), .led_strap_pin_2(strap[1]),
      .led_strap_pin_3(strap[2]), .interrupt_request_pin_n(irq_n), .port_enable(port_on),
      .line_speed_100(spd_o), .line_full_duplex(dup_o), .autoneg_enable(an_o),
      .autoneg_start(), .pads_tristate(tri_o), .regs_ready(ready));
   mdio_station_model mdio_station_model_i (.mdc(mdc), .m_oe(m_oe), .m_out(m_out),
      .line_in(mdio_in), .rd_word(rd_word), .rd_strobe(rd_strobe));
   // ============================================
   // Tasks
   task chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         num_checks++;
         if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] x, input logic e);
      integer n;
      begin
         aq.push_back({!w, e, x});
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= x;
         @(posedge pclk);
         penable <= 1'b1;
         n = 0;
         do begin
            @(posedge pclk);
            n++;
         end while (pready !== 1'b1 && n < 100);
         if (n >= 100) chk(32'(pready), 32'h1);
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task mf(input logic rd, input logic [4:0] p, r, input logic [15:0] v);
      begin
         if (rd) mq.push_back(v);
         mdio_station_model_i.frame(rd, p, r, rd ? 16'h0 : v);
      end
   endtask
   task hw_reset(input logic [2:0] s);
      integer n;
      begin
         @(posedge pclk);
         presetn <= 1'b0;
         strap <= s;
         repeat (16) @(posedge pclk);
         presetn <= 1'b1;
         for (n = 0; n < 200 && ready !== 1'b1; n++) @(posedge pclk);
         chk(32'(ready), 32'h1);
      end
   endtask
   task end_of_test;
      begin
         if (aq.size() + mq.size() != 0) errors++;
         $display("checks %0d, errors %0d", num_checks, errors);
         if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
         else $display("Run complete: FAIL");
         $finish;
      end
   endtask
   // ============================================
   // Result watchers
   always @(posedge pclk) begin
      if (psel && penable && pready) begin
         nt = aq.pop_front();
         if (nt[33]) chk(prdata, nt[31:0]);
         chk(32'(pslverr), 32'(nt[32]));
      end
   end
   always @(posedge rd_strobe) chk(32'(rd_word), 32'(mq.pop_front()));
   // ============================================
   // Tests
   initial begin
      void'($urandom(32'h65df));
      for (i = 0; i < 8; i++) begin
         hw_reset(i[2:0]);
         an = strap[0];
         spd = strap[0] | strap[1];
         dup = strap[2];
         adv = strap[0] ? {dup, 1'b1, strap[1] & dup, strap[1]} : 4'hf;
         chk(32'(irq_n), 32'h1);
         apb(1'b0, 8'h04, {18'h0, spd, an, 3'h0, dup, 8'h0}, 1'b0);
         mf(1'b1, 5'h00, 5'h04, {7'h0, adv, 5'h01});
         chk(32'({port_on, spd_o, dup_o, an_o}), 32'({1'b1, spd, dup, an}));
      end
      $display("straps done");
      d = 16'($urandom);
      mf(1'b0, 5'h00, 5'h1f, d);
      mf(1'b1, 5'h00, 5'h1f, d);
      mf(1'b1, 5'h01, 5'h1f, 16'hffff);
      @(posedge pclk) asel <= 1'b1;
      mf(1'b1, 5'h01, 5'h1f, d);
      @(posedge pclk) asel <= 1'b0;
      @(posedge pclk) dis <= 1'b1;
      mf(1'b0, 5'h00, 5'h1f, ~d);
      mf(1'b1, 5'h00, 5'h1f, 16'hffff);
      apb(1'b0, 8'h04, 32'h0001_3100, 1'b0);
      @(posedge pclk) dis <= 1'b0;
      mf(1'b1, 5'h00, 5'h1f, d);
      $display("modes done");
      mf(1'b0, 5'h00, 5'h00, 16'h3900);
      repeat (4) @(posedge pclk);
      chk(32'(port_on), 32'h0);
      mf(1'b1, 5'h00, 5'h00, 16'h3900);
      // Changed straps must not be picked up again
      @(posedge pclk) strap <= 3'h0;
      mf(1'b0, 5'h00, 5'h00, 16'h8000);
      // Reset still running: busy flag and bit 15 visible
      apb(1'b0, 8'h04, 32'h0004_b100, 1'b0);
      repeat (250) @(posedge pclk);
      apb(1'b0, 8'h04, 32'h0000_3100, 1'b0);
      chk(32'({port_on, spd_o, dup_o, an_o}), 32'hf);
      $display("resets done");
      mf(1'b0, 5'h00, 5'h12, 16'h00f2);
      apb(1'b1, 8'h00, 32'h1, 1'b0);
      repeat (4) @(posedge pclk);
      chk(32'(irq_n), 32'h0);
      mf(1'b1, 5'h00, 5'h13, 16'h0014);
      chk(32'(irq_n), 32'h1);
      mf(1'b0, 5'h00, 5'h12, 16'h00f0);
      apb(1'b1, 8'h00, 32'h0, 1'b0);
      repeat (4) @(posedge pclk);
      chk(32'(irq_n), 32'h1);
      apb(1'b1, 8'h08, 32'h0, 1'b1);
      apb(1'b0, 8'h10, 32'h0, 1'b1);
      $display("interrupts done");
      @(posedge pclk) pd <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(32'(tri_o), 32'h1);
      mf(1'b1, 5'h00, 5'h00, 16'hffff);
      $display("power-down done");
      end_of_test;
   end
   // Whole run is near 19k cycles
   initial begin
      #500000;
      errors++;
      end_of_test;
   end
endmodule // phy_mgmt_config_control_test
